// ### src/hfxc_top.sv
// Fast clock source switch and crystal controller with AHB-Lite registers.
// Assumes analog status inputs are asynchronous and a one-cycle sleep pulse
// from the power manager on hclk.
`timescale 1ns/1ns
`default_nettype none
module hfxc_top
	import hfxc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic pm_sleep_entry,
	input wire logic fast_rc_osc_ready,
	input wire logic osc_running,
	input wire logic amp_high,
	input wire logic amp_low,
	output logic [1:0] high_freq_source_field,
	output logic high_freq_source_run,
	output logic [31:0] fast_rc_osc_freq_mhz,
	output logic [1:0] low_freq_a_source_field,
	output logic [1:0] low_freq_b_source_field,
	output logic [1:0] low_freq_e_source_field,
	output logic xo_core_en,
	output logic external_clock_bypass,
	output logic [6:0] core_bias_trim,
	output logic [7:0] tuning_capacitance,
	output logic [3:0] regulator_current_setting,
	output logic peak_detector_en,
	output logic regulator_low_sel,
	output logic xtal_n_out,
	output logic xtal_n_oe,
	output logic xtal_p_out,
	output logic xtal_p_oe,
	output logic osc_ready_irq
);
	logic dph_q, dwr_q, rdone_q;
	logic [7:0] dad_q;
	logic [31:0] hrdata_q, rd_d;
	logic [7:0] ctrl_q;
	logic [5:0] lfsel_q;
	logic [15:0] stup_q, tmo_q;
	logic [23:0] stdy_q;
	logic [3:0] ien_q, if_q, if_set, if_clr;
	logic [1:0] sel_q;
	logic dead_q, run_q;
	logic [3:0] s1_q, s2_q;
	hfxc_state_t state_q;
	logic rdy_q, pdr_q, sor_q, rc_prev_q;
	logic auto_pd_q, auto_so_q, ext_q, lowp_q;
	logic [1:0] mode_q;
	logic [6:0] bias_q;
	logic [3:0] reg_q;
	logic tm_ld, tm_done, amp_ok, ens;
	logic [15:0] tm_val;
	logic acc, wr;
	logic en_cmd, dis_cmd, pd_cmd, so_cmd, hf_wr;

	// Bus slave; reads take one wait state so they see the latest write
	assign acc = hsel & hready & htrans[1];
	assign wr = dph_q & dwr_q;
	assign hreadyout = !dph_q | dwr_q | rdone_q;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dph_q <= 1'b0;
			dwr_q <= 1'b0;
			dad_q <= 8'h00;
			rdone_q <= 1'b0;
		end else if (acc) begin
			dph_q <= 1'b1;
			dwr_q <= hwrite;
			dad_q <= haddr[7:0];
			rdone_q <= 1'b0;
		end else if (hreadyout) begin
			dph_q <= 1'b0;
			rdone_q <= 1'b0;
		end else begin
			rdone_q <= 1'b1;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h0000_0000;
		end else if (dph_q & !dwr_q & !rdone_q) begin
			hrdata_q <= rd_d;
		end
	end
	always_comb begin
		rd_d = 32'h0000_0000;
		unique case (dad_q)
			A_CTRL: rd_d[7:0] = ctrl_q;
			A_HFSEL: rd_d[1:0] = sel_q;
			A_LFSEL: rd_d[5:0] = lfsel_q;
			A_STUP: rd_d[15:0] = stup_q;
			A_STDY: rd_d[23:0] = stdy_q;
			A_TMO: rd_d[15:0] = tmo_q;
			A_STAT: rd_d[9:0] = {sel_q, 1'b0, dead_q, !run_q, s2_q[3],
				sor_q, pdr_q, rdy_q, ens};
			A_TRIM: begin
				rd_d[F_BIAS+:7] = bias_q;
				rd_d[F_REG+:4] = reg_q;
			end
			A_IF: rd_d[3:0] = if_q;
			A_IEN: rd_d[3:0] = ien_q;
			A_RCF: rd_d = RC_FREQ_MHZ;
			default: rd_d = 32'h0000_0000;
		endcase
	end

	assign en_cmd = wr & (dad_q == A_OSCEN) & hwdata[K_EN];
	assign dis_cmd = wr & (dad_q == A_OSCEN) & hwdata[K_DIS];
	assign pd_cmd = wr & (dad_q == A_CMD) & hwdata[K_PD];
	assign so_cmd = wr & (dad_q == A_CMD) & hwdata[K_SO];
	assign hf_wr = wr & (dad_q == A_HFSEL);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= CTRL_RST;
			lfsel_q <= LFSEL_RST;
			stup_q <= STUP_RST;
			stdy_q <= STDY_RST;
			tmo_q <= TMO_RST;
			ien_q <= 4'h0;
		end else if (wr) begin
			if (dad_q == A_CTRL) ctrl_q <= hwdata[7:0];
			if (dad_q == A_LFSEL) lfsel_q <= hwdata[5:0];
			if (dad_q == A_STUP) stup_q <= hwdata[15:0];
			if (dad_q == A_STDY) stdy_q <= hwdata[23:0];
			if (dad_q == A_TMO) tmo_q <= hwdata[15:0];
			if (dad_q == A_IEN) ien_q <= hwdata[3:0];
		end
	end
	assign low_freq_a_source_field = lfsel_q[1:0];
	assign low_freq_b_source_field = lfsel_q[3:2];
	assign low_freq_e_source_field = lfsel_q[5:4];
	assign fast_rc_osc_freq_mhz = RC_FREQ_MHZ;

	// Two-flop sync of analog status: rc ready, running, amp high, amp low
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_q <= 4'h0;
			s2_q <= 4'h0;
		end else begin
			s1_q <= {fast_rc_osc_ready, osc_running, amp_high, amp_low};
			s2_q <= s1_q;
		end
	end
	assign amp_ok = lowp_q ? s2_q[0] : s2_q[1];

	// Source select; a disabled crystal target can only be undone by reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel_q <= SEL_RC;
			dead_q <= 1'b0;
		end else if (pm_sleep_entry) begin
			sel_q <= SEL_RC;
		end else if (hf_wr) begin
			if (hwdata[1:0] == SEL_RC) sel_q <= SEL_RC;
			if (hwdata[1:0] == SEL_XO) begin
				sel_q <= SEL_XO;
				if (!ens) dead_q <= 1'b1;
			end
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run_q <= 1'b0;
		end else begin
			// Clock halts while the chosen oscillator is not ready
			run_q <= !dead_q & ((sel_q == SEL_RC) ? s2_q[3] : rdy_q);
		end
	end
	assign high_freq_source_field = sel_q;
	assign high_freq_source_run = run_q;

	hfxc_step_timer u_tmr (
		.hclk(hclk),
		.hresetn(hresetn),
		.load(tm_ld),
		.load_val(tm_val),
		.done(tm_done)
	);

	assign ens = (state_q != S_OFF);
	always_comb begin
		tm_ld = 1'b0;
		tm_val = to_cyc(tmo_q[T_PD+:4]);
		unique case (state_q)
			S_OFF: begin
				tm_ld = en_cmd;
				tm_val = to_cyc(tmo_q[T_STUP+:4]);
			end
			S_START: begin
				tm_ld = tm_done;
				tm_val = to_cyc(tmo_q[T_STDY+:4]);
			end
			S_READY: begin
				tm_ld = 1'b1;
				if (!auto_pd_q & (auto_so_q | (so_cmd & !pd_cmd))) begin
					tm_val = to_cyc(tmo_q[T_SO+:4]);
				end
			end
			S_PEAK: tm_ld = tm_done;
			S_SHUNT: begin
				tm_ld = tm_done;
				tm_val = to_cyc(tmo_q[T_SO+:4]);
			end
			default: tm_ld = 1'b0;
		endcase
	end

	// Crystal sequencer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= S_OFF;
			rdy_q <= 1'b0;
			pdr_q <= 1'b0;
			sor_q <= 1'b0;
			auto_pd_q <= 1'b0;
			auto_so_q <= 1'b0;
			mode_q <= MODE_AUTO;
			ext_q <= 1'b0;
			lowp_q <= 1'b0;
			bias_q <= 7'h00;
			reg_q <= 4'h0;
		end else if (dis_cmd | pm_sleep_entry) begin
			state_q <= S_OFF;
			rdy_q <= 1'b0;
			pdr_q <= 1'b0;
			sor_q <= 1'b0;
			auto_pd_q <= 1'b0;
			auto_so_q <= 1'b0;
		end else begin
			unique case (state_q)
				S_OFF: if (en_cmd) begin
					state_q <= S_START;
					// Mode, external and low-power options are taken at start, later writes wait
					mode_q <= ctrl_q[C_MODE+:2];
					ext_q <= ctrl_q[C_EXT];
					lowp_q <= ctrl_q[C_LOWP];
					bias_q <= stdy_q[F_BIAS+:7];
					reg_q <= stdy_q[F_REG+:4];
				end
				S_START: if (tm_done) state_q <= S_STEADY;
				S_STEADY: if (tm_done & s2_q[2]) begin
					state_q <= S_READY;
					rdy_q <= 1'b1;
					// Peak detection has no use on an external wave
					auto_pd_q <= (mode_q == MODE_AUTO) & !ext_q;
					auto_so_q <= (mode_q == MODE_AUTO) & !ext_q;
				end
				S_READY: begin
					if (auto_pd_q | (pd_cmd & !auto_so_q)) begin
						state_q <= S_PEAK;
						auto_pd_q <= 1'b0;
						pdr_q <= 1'b0;
						bias_q <= stdy_q[F_BIAS+:7];
					end else if (auto_so_q | so_cmd) begin
						state_q <= S_SHUNT;
						auto_so_q <= 1'b0;
						sor_q <= 1'b0;
						reg_q <= stdy_q[F_UPR+:4];
					end
				end
				S_PEAK: if (tm_done) begin
					if (amp_ok | (bias_q == 7'h7F)) begin
						state_q <= S_READY;
						pdr_q <= 1'b1;
					end else begin
						bias_q <= bias_q + 7'h01;
					end
				end
				S_SHUNT: if (tm_done) begin
					if (!amp_ok) begin
						// Step back to the last current that held amplitude
						reg_q <= reg_q + 4'h1;
						state_q <= S_READY;
						sor_q <= 1'b1;
					end else if (reg_q == 4'h0) begin
						state_q <= S_READY;
						sor_q <= 1'b1;
					end else begin
						reg_q <= reg_q - 4'h1;
					end
				end
				default: state_q <= S_OFF;
			endcase
		end
	end

	// Analog settings and pins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			xo_core_en <= 1'b0;
			external_clock_bypass <= 1'b0;
			core_bias_trim <= 7'h00;
			tuning_capacitance <= 8'h00;
			regulator_current_setting <= 4'h0;
			peak_detector_en <= 1'b0;
			regulator_low_sel <= 1'b0;
			xtal_n_oe <= 1'b0;
			xtal_p_oe <= 1'b0;
		end else begin
			xo_core_en <= ens & !ext_q;
			external_clock_bypass <= ens & ext_q;
			if (state_q == S_START) begin
				core_bias_trim <= stup_q[F_BIAS+:7];
				tuning_capacitance <= stup_q[F_TUNE+:8];
			end else begin
				core_bias_trim <= bias_q;
				tuning_capacitance <= stdy_q[F_TUNE+:8];
			end
			regulator_current_setting <= reg_q;
			peak_detector_en <= (state_q == S_PEAK) |
				((mode_q == MODE_MAN) & ctrl_q[C_MPD]);
			regulator_low_sel <= (mode_q == MODE_MAN) & ctrl_q[C_MRS];
			xtal_n_oe <= !ens & ctrl_q[C_GND_IN];
			xtal_p_oe <= !ens & ctrl_q[C_GND_OUT];
		end
	end
	assign xtal_n_out = 1'b0;
	assign xtal_p_out = 1'b0;

	// Ready flags; a set in the clear cycle wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rc_prev_q <= 1'b0;
			if_q <= 4'h0;
			osc_ready_irq <= 1'b0;
		end else begin
			rc_prev_q <= s2_q[3];
			if_q <= (if_q & ~if_clr) | if_set;
			osc_ready_irq <= |(if_q & ien_q);
		end
	end
	assign if_clr = (wr & (dad_q == A_IF)) ? hwdata[3:0] : 4'h0;
	assign if_set = {s2_q[3] & !rc_prev_q,
		(state_q == S_SHUNT) & tm_done & (!amp_ok | (reg_q == 4'h0)),
		(state_q == S_PEAK) & tm_done & (amp_ok | (bias_q == 7'h7F)),
		(state_q == S_STEADY) & tm_done & s2_q[2]};

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sleep_rc_sel_a: assert property (pm_sleep_entry |=> sel_q == SEL_RC)
		else $error("sleep did not return to fast rc");
	hf_write_sel_a: assert property (hf_wr && hwdata[1:0] == SEL_XO &&
		!pm_sleep_entry |=> sel_q == SEL_XO)
		else $error("crystal select not taken");
	dead_stop_a: assert property (dead_q |=> !run_q [*3])
		else $error("clock ran after dead select");
	unready_stall_a: assert property (sel_q == SEL_XO && !rdy_q |=> !run_q)
		else $error("clock ran on unready crystal");
	ready_osc_a: assert property ($rose(rdy_q) |-> $past(s2_q[2]) &&
		$past(state_q) == S_STEADY)
		else $error("ready without oscillation");
	steady_order_a: assert property (state_q == S_STEADY |->
		$past(state_q) inside {S_START, S_STEADY})
		else $error("steady not reached from startup");
	pin_ground_a: assert property (!ens && ctrl_q[C_GND_IN] &&
		!en_cmd |=> xtal_n_oe)
		else $error("input pin not grounded");
	cmd_no_auto_a: assert property (state_q == S_STEADY &&
		mode_q == MODE_CMD |=> !auto_pd_q && !auto_so_q)
		else $error("auto run armed in command mode");
	manual_ignored_a: assert property (state_q != S_PEAK &&
		mode_q != MODE_MAN |=> !peak_detector_en)
		else $error("manual peak bit not ignored");
	flag_set_wins_a: assert property (if_set[I_XRDY] |=> if_q[I_XRDY])
		else $error("ready flag lost");
	ready_cov: cover property ($rose(rdy_q));
	peak_cov: cover property ($rose(pdr_q));
	shunt_cov: cover property ($rose(sor_q));
	dead_cov: cover property ($rose(dead_q));
endmodule
`default_nettype wire

// ### src/hfxc_pkg.sv
// Constants, field layout and state type of the fast clock switch and
// crystal controller. Assumes a 250 MHz hclk and 32-bit AHB-Lite words.
package hfxc_pkg;
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_OSCEN = 8'h04;
	localparam logic [7:0] A_HFSEL = 8'h08;
	localparam logic [7:0] A_LFSEL = 8'h0C;
	localparam logic [7:0] A_STUP = 8'h10;
	localparam logic [7:0] A_STDY = 8'h14;
	localparam logic [7:0] A_TMO = 8'h18;
	localparam logic [7:0] A_CMD = 8'h1C;
	localparam logic [7:0] A_STAT = 8'h20;
	localparam logic [7:0] A_TRIM = 8'h24;
	localparam logic [7:0] A_IF = 8'h28;
	localparam logic [7:0] A_IEN = 8'h2C;
	localparam logic [7:0] A_RCF = 8'h30;
	// Control fields
	localparam int C_EXT = 0;
	localparam int C_GND_IN = 1;
	localparam int C_GND_OUT = 2;
	localparam int C_LOWP = 3;
	localparam int C_MODE = 4;
	localparam int C_MPD = 6;
	localparam int C_MRS = 7;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [1:0] MODE_AUTO = 2'h0;
	localparam logic [1:0] MODE_CMD = 2'h1;
	localparam logic [1:0] MODE_MAN = 2'h2;
	// Command bits
	localparam int K_EN = 0;
	localparam int K_DIS = 1;
	localparam int K_PD = 0;
	localparam int K_SO = 1;
	// Source codes
	localparam logic [1:0] SEL_RC = 2'h1;
	localparam logic [1:0] SEL_XO = 2'h2;
	// Field positions of startup, steady, timeout and trim words
	localparam int F_BIAS = 0;
	localparam int F_TUNE = 8;
	localparam int F_REG = 16;
	localparam int F_UPR = 20;
	localparam int T_STUP = 0;
	localparam int T_STDY = 4;
	localparam int T_PD = 8;
	localparam int T_SO = 12;
	localparam logic [15:0] STUP_RST = 16'h0000;
	localparam logic [23:0] STDY_RST = 24'h00_0000;
	localparam logic [15:0] TMO_RST = 16'h0000;
	localparam logic [5:0] LFSEL_RST = 6'h00;
	// Flag bits
	localparam int I_XRDY = 0;
	localparam int I_PDR = 1;
	localparam int I_SOR = 2;
	localparam int I_RCR = 3;
	localparam logic [31:0] RC_FREQ_MHZ = 32'h0000_0013;
	// Timeouts: code c lasts (c+1) units
	localparam int CLK_NS = 4;
	localparam int TO_UNIT_NS = 64;
	localparam logic [15:0] TO_UNIT_CYC =
		16'((TO_UNIT_NS + CLK_NS - 1) / CLK_NS);
	typedef enum logic [2:0] {
		S_OFF, S_START, S_STEADY, S_READY, S_PEAK, S_SHUNT
	} hfxc_state_t;
	function automatic logic [15:0] to_cyc(input logic [3:0] c);
		return ({12'h000, c} + 16'h0001) * TO_UNIT_CYC;
	endfunction
endpackage

// ### src/hfxc_step_timer.sv
// Down counter timing crystal phases and algorithm steps.
// Assumes load values of at least one cycle.
`timescale 1ns/1ns
`default_nettype none
module hfxc_step_timer (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic load,
	input wire logic [15:0] load_val,
	output logic done
);
	logic [15:0] cnt_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 16'h0000;
		end else if (load) begin
			cnt_q <= load_val;
		end else if (cnt_q != 16'h0000) begin
			cnt_q <= cnt_q - 16'h0001;
		end
	end
	assign done = (cnt_q == 16'h0000);
endmodule
`default_nettype wire

// ### dv/hfxc_xtal_model.sv
// Behavioural crystal or external clock at the far side of the controller.
// Assumes the controller's core enable, bias and regulator outputs.
`timescale 1ns/1ns
`default_nettype none
module hfxc_xtal_model #(
	parameter int BH = 30,
	parameter int BL = 24,
	parameter int RMIN = 5
) (
	input wire logic xo_core_en,
	input wire logic external_clock_bypass,
	input wire logic [6:0] core_bias_trim,
	input wire logic [3:0] regulator_current_setting,
	input wire logic slow,
	output logic osc_running,
	output logic amp_high,
	output logic amp_low
);
	logic on;
	logic reg_ok;
	assign on = xo_core_en | external_clock_bypass;
	assign reg_ok = regulator_current_setting >= 4'(RMIN);
	// Slow start outlasts the timeouts, so ready must wait for it
	always begin
		osc_running = 1'b0;
		wait (on);
		#(slow ? 2000 : 200);
		if (on) begin
			osc_running = 1'b1;
			wait (!on);
		end
	end
	// Amplitude needs enough bias and enough shunt current
	assign amp_high = osc_running && reg_ok && core_bias_trim >= 7'(BH);
	assign amp_low = osc_running && reg_ok && core_bias_trim >= 7'(BL);
endmodule
`default_nettype wire

// ### dv/test_hf_clock_switch_and_xtal_osc_ctrl.sv
// Self-checking bench of the fast clock switch and crystal controller.
// Assumes the crystal model beside it and AHB-Lite with one slave.
`timescale 1ns/1ns
`default_nettype none
module test_hf_clock_switch_and_xtal_osc_ctrl
	import hfxc_pkg::*;
;
	localparam int BH = 30;
	localparam int BL = 24;
	localparam int RMIN = 5;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, fast_rc_osc_freq_mhz;
	logic [1:0] htrans, high_freq_source_field;
	logic [2:0] hsize;
	logic pm_sleep_entry, fast_rc_osc_ready, osc_running, amp_high, amp_low;
	logic [1:0] low_freq_a_source_field, low_freq_b_source_field;
	logic [1:0] low_freq_e_source_field;
	logic high_freq_source_run, xo_core_en, external_clock_bypass, slow;
	logic [6:0] core_bias_trim;
	logic [7:0] tuning_capacitance;
	logic [3:0] regulator_current_setting;
	logic peak_detector_en, regulator_low_sel, osc_ready_irq;
	logic xtal_n_out, xtal_n_oe, xtal_p_out, xtal_p_oe, rdy_s;
	logic [31:0] rd_s, rdv, rnd;
	int n_errors, cmp_count, i;

	assign hready = hreadyout;
	hfxc_top hfxc_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
		.pm_sleep_entry, .fast_rc_osc_ready, .osc_running, .amp_high,
		.amp_low, .high_freq_source_field, .high_freq_source_run,
		.fast_rc_osc_freq_mhz, .low_freq_a_source_field,
		.low_freq_b_source_field, .low_freq_e_source_field, .xo_core_en,
		.external_clock_bypass, .core_bias_trim, .tuning_capacitance,
		.regulator_current_setting, .peak_detector_en, .regulator_low_sel,
		.xtal_n_out, .xtal_n_oe, .xtal_p_out, .xtal_p_oe, .osc_ready_irq);
	hfxc_xtal_model #(.BH(BH), .BL(BL), .RMIN(RMIN)) hfxc_xtal_model_i (
		.xo_core_en, .external_clock_bypass, .core_bias_trim,
		.regulator_current_setting, .slow, .osc_running, .amp_high,
		.amp_low);

	always #2 hclk = ~hclk;
	// Outputs move only at rising edges, so this is what the next edge sees
	always @(negedge hclk) begin
		rdy_s = hreadyout;
		rd_s = hrdata;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic int peak_exp(input int b, input int t);
		while (b < t && b < 127) b++;
		return b;
	endfunction
	function automatic int shunt_exp(input int r);
		while (r >= RMIN && r > 0) r--;
		return (r < RMIN) ? r + 1 : r;
	endfunction

	task automatic stop_test;
		$display("n_errors=%0d cmp_count=%0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
	endtask
	// Called just after a rising edge; holds each phase until hready
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge hclk); while (rdy_s !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (rdy_s !== 1'b1);
		rdv = rd_s;
	endtask
	task automatic wait_st(input int b);
		for (int k = 0; k < 400; k++) begin
			xfer(1'b0, A_STAT, 32'h0000_0000);
			if (rdv[b] === 1'b1) break;
		end
		chk(32'(rdv[b]), 32'h0000_0001);
	endtask
	task automatic do_reset;
		hresetn <= 1'b0;
		tick(10);
		hresetn <= 1'b1;
		tick(6);
	endtask
	task automatic sleep;
		pm_sleep_entry <= 1'b1;
		tick(1);
		pm_sleep_entry <= 1'b0;
		tick(3);
	endtask
	task automatic run_xtal(input logic [7:0] ctrl, input logic sl,
		input int osc_cyc);
		int t0;
		int ex;
		slow <= sl;
		xfer(1'b1, A_CTRL, 32'(ctrl));
		xfer(1'b1, A_STUP, 32'h0000_5a11);
		xfer(1'b1, A_STDY, 32'h0085_6614);
		xfer(1'b1, A_TMO, 32'h0000_0021);
		xfer(1'b1, A_IEN, 32'h0000_0001);
		t0 = int'($time);
		xfer(1'b1, A_OSCEN, 32'h0000_0001);
		tick(2);
		chk(32'(core_bias_trim), 32'h0000_0011);
		chk(32'(tuning_capacitance), 32'h0000_005a);
		xfer(1'b0, A_STAT, 32'h0000_0000);
		chk(32'(rdv[1:0]), 32'h0000_0001);
		wait_st(1);
		ex = (2 + 3) * int'(TO_UNIT_CYC);
		if (osc_cyc > ex) ex = osc_cyc;
		chk(32'((int'($time) - t0) / 4 >= ex), 32'h0000_0001);
		chk(32'(osc_ready_irq), 32'h0000_0001);
	endtask

	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		pm_sleep_entry = 1'b0;
		fast_rc_osc_ready = 1'b1;
		slow = 1'b0;
		n_errors = 0;
		cmp_count = 0;
		rnd = 32'h51f4_8acf;
		do_reset;
		chk(32'(high_freq_source_field), 32'(SEL_RC));
		chk(32'(high_freq_source_run), 32'h0000_0001);
		chk(fast_rc_osc_freq_mhz, 32'h0000_0013);
		xfer(1'b0, A_RCF, 32'h0000_0000);
		chk(rdv, 32'h0000_0013);
		xfer(1'b1, 8'h40, rnd);
		xfer(1'b0, 8'h40, 32'h0000_0000);
		chk(rdv, 32'h0000_0000);
		for (i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			xfer(1'b1, A_LFSEL, rnd);
			tick(1);
			chk(32'({low_freq_e_source_field, low_freq_b_source_field,
				low_freq_a_source_field}), 32'(rnd[5:0]));
		end
		// No external wave here, so grounding the input pin is allowed
		for (i = 0; i < 4; i++) begin
			xfer(1'b1, A_CTRL, 32'(i * 2));
			tick(2);
			chk(32'({xtal_p_oe, xtal_n_oe, xtal_p_out, xtal_n_out}),
				32'(i * 4));
		end
		run_xtal(8'h00, 1'b0, 50);
		wait_st(3);
		xfer(1'b0, A_TRIM, 32'h0000_0000);
		chk(32'(rdv[6:0]), 32'(peak_exp(20, BH)));
		chk(32'(rdv[19:16]), 32'(shunt_exp(8)));
		xfer(1'b1, A_HFSEL, 32'(SEL_XO));
		tick(4);
		chk(32'(high_freq_source_field), 32'(SEL_XO));
		chk(32'(high_freq_source_run), 32'h0000_0001);
		xfer(1'b1, A_IF, 32'h0000_000f);
		tick(2);
		chk(32'(osc_ready_irq), 32'h0000_0000);
		sleep();
		chk(32'(high_freq_source_field), 32'(SEL_RC));
		run_xtal(8'hd8, 1'b1, 500);
		chk(32'(core_bias_trim), 32'h0000_0014);
		chk(32'(regulator_current_setting), 32'h0000_0005);
		tick(100);
		// Manual bits are set here but command mode must ignore them
		chk(32'(peak_detector_en), 32'h0000_0000);
		chk(32'(regulator_low_sel), 32'h0000_0000);
		chk(32'(xo_core_en), 32'h0000_0001);
		chk(32'(tuning_capacitance), 32'h0000_0066);
		xfer(1'b0, A_STAT, 32'h0000_0000);
		chk(32'(rdv[3:2]), 32'h0000_0000);
		xfer(1'b1, A_CMD, 32'h0000_0001);
		wait_st(2);
		xfer(1'b0, A_TRIM, 32'h0000_0000);
		chk(32'(rdv[6:0]), 32'(peak_exp(20, BL)));
		xfer(1'b1, A_CMD, 32'h0000_0002);
		wait_st(3);
		xfer(1'b0, A_TRIM, 32'h0000_0000);
		chk(32'(rdv[19:16]), 32'(shunt_exp(8)));
		sleep();
		slow <= 1'b0;
		// External clock in manual mode: both manual bits take effect
		xfer(1'b1, A_CTRL, 32'h0000_00e1);
		xfer(1'b1, A_OSCEN, 32'h0000_0001);
		xfer(1'b1, A_HFSEL, 32'(SEL_XO));
		tick(2);
		chk(32'(high_freq_source_run), 32'h0000_0000);
		chk(32'(external_clock_bypass), 32'h0000_0001);
		chk(32'(xo_core_en), 32'h0000_0000);
		chk(32'(peak_detector_en), 32'h0000_0001);
		chk(32'(regulator_low_sel), 32'h0000_0001);
		wait_st(1);
		tick(4);
		chk(32'(high_freq_source_run), 32'h0000_0001);
		// Selecting the disabled crystal on purpose: only reset recovers
		sleep();
		xfer(1'b1, A_HFSEL, 32'(SEL_XO));
		tick(4);
		chk(32'(high_freq_source_run), 32'h0000_0000);
		xfer(1'b0, A_STAT, 32'h0000_0000);
		chk(32'(rdv[6]), 32'h0000_0001);
		do_reset;
		chk(32'(high_freq_source_field), 32'(SEL_RC));
		chk(32'(high_freq_source_run), 32'h0000_0001);
		stop_test;
	end

	initial begin
		#200_000;
		n_errors++;
		stop_test;
	end
endmodule
`default_nettype wire
